// *** verilog/dsg_defs.svh ***
`ifndef DSG_DEFS_SVH
`define DSG_DEFS_SVH
// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define DSG_OFS_GATE 12'h120
`define DSG_OFS_STAT 12'h124
`define DSG_OFS_MASK 12'h128
`define DSG_OFS_EFF 12'h12C
// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define DSG_BIT_CONV 16
`define DSG_BIT_HIB 6
`define DSG_BIT_WDOG 3
`define DSG_RATE_HI 9
`define DSG_RATE_LO 8
`define DSG_GATE_RESET 32'h0000_0040
`define DSG_GATE_WMASK 32'h0001_0348
`define DSG_IRQ_WMASK 32'h0000_0007
`define DSG_RATE_125K 2'h0
`define DSG_RATE_250K 2'h1
`define DSG_RATE_500K 2'h2
`define DSG_RATE_MAX 2'h2
// ----------------------------------------------------------------
// Bus responses
// ----------------------------------------------------------------
`define DSG_RESP_OKAY 2'h0
`define DSG_RESP_SLVERR 2'h2
`endif

// *** verilog/dsg_pkg.sv ***
package dsg_pkg;
  // Power state of the system
  typedef enum logic [1:0] {mode_run, mode_sleep, mode_deep} power_mode_t;
  // One flag per gated unit
  typedef struct packed {
    logic converter;
    logic hibernation;
    logic watchdog;
  } unit_set_t;
  // Layout of a gating word
  typedef struct packed {
    logic [14:0] rsv_hi;
    logic converter_clock_gate;
    logic [5:0] rsv_mid;
    logic [1:0] converter_sample_rate_sel;
    logic rsv_7;
    logic hibernation_clock_gate;
    logic [1:0] rsv_54;
    logic watchdog_clock_gate;
    logic [2:0] rsv_lo;
  } gate_word_t;
endpackage

// *** verilog/gate_select.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "dsg_defs.svh"
module gate_select (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Word selection
  input wire dsg_pkg::power_mode_t power_mode,
  input wire logic auto_clock_gating_enable,
  input wire logic [31:0] run_word,
  input wire logic [31:0] sleep_word,
  input wire logic [31:0] deep_word,
  // Unit side
  input wire dsg_pkg::unit_set_t unit_access,
  output dsg_pkg::unit_set_t unit_clock_enable,
  output logic [1:0] converter_sample_rate_sel,
  output dsg_pkg::unit_set_t unit_access_fault
);
  import dsg_pkg::*;

  gate_word_t active;

  // Pick the word for the present power state
  always_comb begin
    active = gate_word_t'(run_word);
    if (auto_clock_gating_enable) begin
      case (power_mode)
        mode_sleep: active = gate_word_t'(sleep_word);
        mode_deep: active = gate_word_t'(deep_word);
        default: active = gate_word_t'(run_word);
      endcase
    end
  end

  // Clock enables and sample rate, registered
  always_ff @(posedge mclk) begin
    if (reset) begin
      unit_clock_enable <= '0;
      converter_sample_rate_sel <= `DSG_RATE_125K;
    end else begin
      unit_clock_enable.converter <= active.converter_clock_gate;
      unit_clock_enable.hibernation <= active.hibernation_clock_gate;
      unit_clock_enable.watchdog <= active.watchdog_clock_gate;
      converter_sample_rate_sel <= active.converter_sample_rate_sel;
    end
  end

  // Access to an unclocked unit
  always_ff @(posedge mclk) begin
    if (reset) begin
      unit_access_fault <= '0;
    end else begin
      unit_access_fault <= unit_access & ~unit_clock_enable;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  property p_wdog_fault;
    unit_access.watchdog && !unit_clock_enable.watchdog
      |=> unit_access_fault.watchdog;
  endproperty
  a_wdog_fault: assert property (p_wdog_fault)
    else $error("gated watchdog access did not fault");

  property p_no_false_fault;
    !unit_access.converter || unit_clock_enable.converter
      |=> !unit_access_fault.converter;
  endproperty
  a_no_false_fault: assert property (p_no_false_fault)
    else $error("fault without gated access");

  property p_run_word;
    !auto_clock_gating_enable |=> unit_clock_enable.converter ==
      $past(run_word[`DSG_BIT_CONV]);
  endproperty
  a_run_word: assert property (p_run_word)
    else $error("run word not applied without auto gating");

  property p_sleep_word;
    auto_clock_gating_enable && power_mode == mode_sleep
      |=> unit_clock_enable.hibernation ==
          $past(sleep_word[`DSG_BIT_HIB]);
  endproperty
  a_sleep_word: assert property (p_sleep_word)
    else $error("sleep word not applied");

  property p_deep_needs_acg;
    power_mode == mode_deep && !auto_clock_gating_enable
      |=> converter_sample_rate_sel ==
          $past(run_word[`DSG_RATE_HI:`DSG_RATE_LO]);
  endproperty
  a_deep_needs_acg: assert property (p_deep_needs_acg)
    else $error("deep word used without auto gating");
endmodule
`default_nettype wire

// *** verilog/deep_sleep_clock_gate_bank0.sv ***
// Notes on behaviour
// - Each gate bit enables one unit clock
// - Access to gated unit gives bus fault
// - Gate bits 16 and 3 reset to zero, bit 6 to one
// - Whole word resets to 0x00000040
// - Three words: run, sleep, deep sleep
// - Sleep words need auto gating enabled
// - Bit 16 gates converter unit zero
// - Bits 9:8 select converter sample rate
// - Deep-sleep word rate never set above maximum rate
// - Bit 6 gates hibernation unit
// - Bit 3 gates watchdog unit
// - Reserved bits read zero, unwritable
`timescale 1ns/1ps
`default_nettype none
`include "dsg_defs.svh"
module deep_sleep_clock_gate_bank0 (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // AXI4-Lite write address
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [11:0] s_axi_awaddr,
  // AXI4-Lite write data
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  // AXI4-Lite write response
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  // AXI4-Lite read
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [11:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // Power state and the other gating words
  input wire dsg_pkg::power_mode_t power_mode,
  input wire logic auto_clock_gating_enable,
  input wire logic [31:0] run_clock_gate_0,
  input wire logic [31:0] sleep_clock_gate_0,
  // Gated units
  input wire dsg_pkg::unit_set_t unit_access,
  output dsg_pkg::unit_set_t unit_clock_enable,
  output logic [1:0] converter_sample_rate_sel,
  output dsg_pkg::unit_set_t unit_access_fault,
  // Interrupt
  output logic irq
);
  import dsg_pkg::*;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Byte-lane merge of a write
  function automatic logic [31:0] apply_strobe(input logic [31:0] old,
      input logic [31:0] data, input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = data[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // Limit the sample rate code to the maximum rate
  function automatic logic [31:0] clamp_rate(input logic [31:0] w);
    logic [31:0] res;
    res = w;
    if (w[`DSG_RATE_HI:`DSG_RATE_LO] > `DSG_RATE_MAX) begin
      res[`DSG_RATE_HI:`DSG_RATE_LO] = `DSG_RATE_MAX;
    end
    return res;
  endfunction

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [31:0] deep_sleep_clock_gate_0;
  logic [2:0] irq_status;
  logic [2:0] irq_mask;
  logic aw_held;
  logic w_held;
  logic [11:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic do_write;
  logic [31:0] next_gate;
  logic [31:0] eff_word;
  logic [2:0] fault_events;
  // Word indices of the mapped registers
  localparam logic [9:0] idx_gate = 10'(`DSG_OFS_GATE >> 2);
  localparam logic [9:0] idx_stat = 10'(`DSG_OFS_STAT >> 2);
  localparam logic [9:0] idx_mask = 10'(`DSG_OFS_MASK >> 2);
  localparam logic [9:0] idx_eff = 10'(`DSG_OFS_EFF >> 2);

  // ----------------------------------------------------------------
  // Write channel
  // ----------------------------------------------------------------
  assign s_axi_awready = !aw_held;
  assign s_axi_wready = !w_held;
  assign do_write = aw_held && w_held && !s_axi_bvalid;

  // Address and data are caught in either order
  always_ff @(posedge mclk) begin
    if (reset) begin
      aw_held <= 1'b0;
      aw_addr <= 12'h000;
    end else if (s_axi_awvalid && !aw_held) begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end else if (do_write) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      w_held <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else if (s_axi_wvalid && !w_held) begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end else if (do_write) begin
      w_held <= 1'b0;
    end
  end

  // Write response, one cycle after both halves are held
  always_ff @(posedge mclk) begin
    if (reset) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `DSG_RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      case (aw_addr[11:2])
        idx_gate, idx_stat,
        idx_mask, idx_eff:
          s_axi_bresp <= `DSG_RESP_OKAY;
        default: s_axi_bresp <= `DSG_RESP_SLVERR;
      endcase
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // New gating word from a write
  always_comb begin
    next_gate = (apply_strobe(deep_sleep_clock_gate_0, w_data, w_strb)
                 & `DSG_GATE_WMASK);
    next_gate = clamp_rate(next_gate);
  end

  // Deep-sleep gating word
  always_ff @(posedge mclk) begin
    if (reset) begin
      deep_sleep_clock_gate_0 <= `DSG_GATE_RESET;
    end else if (do_write && aw_addr[11:2] == idx_gate) begin
      deep_sleep_clock_gate_0 <= next_gate;
    end
  end

  // Interrupt mask
  always_ff @(posedge mclk) begin
    if (reset) begin
      irq_mask <= 3'h0;
    end else if (do_write && aw_addr[11:2] == idx_mask) begin
      irq_mask <= w_strb[0] ? w_data[2:0] : irq_mask;
    end
  end

  // Sticky fault status, cleared by writing one; a new fault wins
  always_ff @(posedge mclk) begin
    if (reset) begin
      irq_status <= 3'h0;
    end else if (do_write && aw_addr[11:2] == idx_stat) begin
      irq_status <= (irq_status & ~(w_data[2:0] & {3{w_strb[0]}}))
                    | fault_events;
    end else begin
      irq_status <= irq_status | fault_events;
    end
  end

  assign fault_events = unit_access_fault;
  assign irq = |(irq_status & irq_mask);

  // ----------------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------------
  assign s_axi_arready = !s_axi_rvalid;

  // Enables now applied, in gating word layout
  always_comb begin
    eff_word = 32'h0000_0000;
    eff_word[`DSG_BIT_CONV] = unit_clock_enable.converter;
    eff_word[`DSG_BIT_HIB] = unit_clock_enable.hibernation;
    eff_word[`DSG_BIT_WDOG] = unit_clock_enable.watchdog;
    eff_word[`DSG_RATE_HI:`DSG_RATE_LO] = converter_sample_rate_sel;
  end

  // Read data registered one cycle after the address
  always_ff @(posedge mclk) begin
    if (reset) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `DSG_RESP_OKAY;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `DSG_RESP_OKAY;
      case (s_axi_araddr[11:2])
        idx_gate: s_axi_rdata <= deep_sleep_clock_gate_0;
        idx_stat: s_axi_rdata <= {29'h0, irq_status};
        idx_mask: s_axi_rdata <= {29'h0, irq_mask};
        idx_eff: s_axi_rdata <= eff_word;
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= `DSG_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Gate selection
  // ----------------------------------------------------------------
  gate_select u_select (
    .mclk(mclk),
    .reset(reset),
    .power_mode(power_mode),
    .auto_clock_gating_enable(auto_clock_gating_enable),
    .run_word(run_clock_gate_0),
    .sleep_word(sleep_clock_gate_0),
    .deep_word(deep_sleep_clock_gate_0),
    .unit_access(unit_access),
    .unit_clock_enable(unit_clock_enable),
    .converter_sample_rate_sel(converter_sample_rate_sel),
    .unit_access_fault(unit_access_fault)
  );

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  logic deep_active;
  assign deep_active = auto_clock_gating_enable && power_mode == mode_deep;

  property p_conv_follow;
    deep_active |=> unit_clock_enable.converter ==
      $past(deep_sleep_clock_gate_0[`DSG_BIT_CONV]);
  endproperty
  a_conv_follow: assert property (p_conv_follow)
    else $error("converter enable does not follow gate bit");

  property p_hib_follow;
    deep_active |=> unit_clock_enable.hibernation ==
      $past(deep_sleep_clock_gate_0[`DSG_BIT_HIB]);
  endproperty
  a_hib_follow: assert property (p_hib_follow)
    else $error("hibernation enable does not follow gate bit");

  property p_held_word;
    deep_active ##1 $stable(deep_sleep_clock_gate_0)
      |-> unit_clock_enable.watchdog ==
          deep_sleep_clock_gate_0[`DSG_BIT_WDOG];
  endproperty
  a_held_word: assert property (p_held_word)
    else $error("watchdog enable differs from held word");

  property p_reset_word;
    @(posedge mclk) disable iff (1'b0)
    reset |=> deep_sleep_clock_gate_0 == `DSG_GATE_RESET;
  endproperty
  a_reset_word: assert property (p_reset_word)
    else $error("gate word wrong after reset");

  property p_reset_off;
    @(posedge mclk) disable iff (1'b0)
    reset |=> unit_clock_enable == '0 && unit_access_fault == '0;
  endproperty
  a_reset_off: assert property (p_reset_off)
    else $error("units clocked during reset");

  property p_rate_limit;
    deep_sleep_clock_gate_0[`DSG_RATE_HI:`DSG_RATE_LO] <= `DSG_RATE_MAX;
  endproperty
  a_rate_limit: assert property (p_rate_limit)
    else $error("sample rate above maximum");

  property p_rate_follow;
    deep_active |=> converter_sample_rate_sel ==
      $past(deep_sleep_clock_gate_0[`DSG_RATE_HI:`DSG_RATE_LO]);
  endproperty
  a_rate_follow: assert property (p_rate_follow)
    else $error("sample rate does not follow field");

  property p_reserved_zero;
    (deep_sleep_clock_gate_0 & ~`DSG_GATE_WMASK) == 32'h0000_0000;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("reserved gate bit set");

  property p_bvalid_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid [*1] ##0 $stable(s_axi_bresp);
  endproperty
  a_bvalid_hold: assert property (p_bvalid_hold)
    else $error("write response dropped before bready");

  c_fault_irq: cover property (unit_access_fault.watchdog ##1 irq);
  c_deep_write: cover property (do_write ##1 deep_active ##1
    unit_clock_enable.converter);
  c_clamp: cover property (do_write && w_data[9:8] == 2'h3);
endmodule
`default_nettype wire

// *** verification/deep_sleep_clock_gate_bank0_test.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "dsg_defs.svh"
// Compare two values, count it, report a mismatch at once
`define CHECK(got, exp) \
  begin \
    tests_run++; \
    if ((got) !== (exp)) begin \
      err_total++; \
      $display("[FAIL] %0t got %h expected %h", $time, (got), (exp)); \
    end \
  end
module deep_sleep_clock_gate_bank0_test;
  import dsg_pkg::*;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic mclk, reset;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  logic [1:0] s_axi_bresp, s_axi_rresp, converter_sample_rate_sel;
  power_mode_t power_mode;
  logic auto_clock_gating_enable, irq;
  logic [31:0] run_clock_gate_0, sleep_clock_gate_0;
  unit_set_t unit_access, unit_clock_enable, unit_access_fault;
  int err_total, tests_run;
  logic [31:0] d;
  logic [1:0] r;
  // ----------------------------------------------------------------
  // Design under test
  // ----------------------------------------------------------------
  deep_sleep_clock_gate_bank0 i_dut (
    .mclk(mclk), .reset(reset),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .power_mode(power_mode),
    .auto_clock_gating_enable(auto_clock_gating_enable),
    .run_clock_gate_0(run_clock_gate_0),
    .sleep_clock_gate_0(sleep_clock_gate_0),
    .unit_access(unit_access), .unit_clock_enable(unit_clock_enable),
    .converter_sample_rate_sel(converter_sample_rate_sel),
    .unit_access_fault(unit_access_fault), .irq(irq)
  );
  // ----------------------------------------------------------------
  // Clock, closing and watchdog
  // ----------------------------------------------------------------
  // 25 MHz system clock
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  // Print the counts and the verdict, then stop
  task automatic test_done;
    $display("Checks %0d, mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // Cut a hang short well after the expected run length
  initial begin
    repeat (5000) @(posedge mclk);
    err_total++;
    test_done();
  end
  // ----------------------------------------------------------------
  // Bus tasks, entered just after a rising edge
  // ----------------------------------------------------------------
  // Write one word; address and data released as each is taken
  task automatic axi_write(input logic [11:0] a, input logic [31:0] v,
                           output logic [1:0] resp);
    logic aw_t, w_t;
    aw_t = 1'b0;
    w_t = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw_t && w_t)) begin
      @(negedge mclk);
      if (s_axi_awvalid && s_axi_awready) aw_t = 1'b1;
      if (s_axi_wvalid && s_axi_wready) w_t = 1'b1;
      @(posedge mclk);
      if (aw_t) s_axi_awvalid <= 1'b0;
      if (w_t) s_axi_wvalid <= 1'b0;
    end
    do @(negedge mclk); while (!s_axi_bvalid);
    resp = s_axi_bresp;
    @(posedge mclk);
  endtask
  // Read one word
  task automatic axi_read(input logic [11:0] a, output logic [31:0] v,
                          output logic [1:0] resp);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(negedge mclk); while (!s_axi_arready);
    @(posedge mclk);
    s_axi_arvalid <= 1'b0;
    do @(negedge mclk); while (!s_axi_rvalid);
    v = s_axi_rdata;
    resp = s_axi_rresp;
    @(posedge mclk);
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  // Outputs and registers straight after reset
  task automatic test_reset;
    @(negedge mclk);
    `CHECK(unit_clock_enable, 3'h0)
    `CHECK(irq, 1'b0)
    @(posedge mclk);
    axi_read(`DSG_OFS_GATE, d, r);
    `CHECK(d, `DSG_GATE_RESET)
    axi_read(`DSG_OFS_MASK, d, r);
    `CHECK(d, 32'h0000_0000)
  endtask
  // Reserved bits, rate codes, clamp, unmapped place, second reset
  task automatic test_regs;
    power_mode <= mode_deep;
    auto_clock_gating_enable <= 1'b1;
    axi_write(`DSG_OFS_GATE, 32'hFFFF_FFFF, r);
    `CHECK(r, `DSG_RESP_OKAY)
    axi_read(`DSG_OFS_GATE, d, r);
    `CHECK(d, 32'h0001_0248)
    for (int c = 0; c < 3; c++) begin
      axi_write(`DSG_OFS_GATE, 32'h0001_0000 | (32'(c) << 8), r);
      axi_read(`DSG_OFS_GATE, d, r);
      `CHECK(d, 32'h0001_0000 | (32'(c) << 8))
      `CHECK(converter_sample_rate_sel, 2'(c))
      `CHECK(unit_clock_enable.converter, 1'b1)
    end
    axi_write(12'h200, 32'hFFFF_FFFF, r);
    `CHECK(r, `DSG_RESP_SLVERR)
    axi_read(12'h200, d, r);
    `CHECK(r, `DSG_RESP_SLVERR)
    `CHECK(d, 32'h0000_0000)
    reset <= 1'b1;
    repeat (3) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    axi_read(`DSG_OFS_GATE, d, r);
    `CHECK(d, `DSG_GATE_RESET)
  endtask
  // Word chosen by power state and auto gating
  task automatic test_select;
    logic [31:0] e;
    run_clock_gate_0 <= 32'h0000_0008;
    sleep_clock_gate_0 <= 32'h0000_0140;
    axi_write(`DSG_OFS_GATE, 32'h0001_0240, r);
    for (int a = 0; a < 2; a++) begin
      for (int m = 0; m < 3; m++) begin
        auto_clock_gating_enable <= a[0];
        power_mode <= power_mode_t'(m);
        repeat (2) @(posedge mclk);
        @(negedge mclk);
        e = (a == 1 && m == 1) ? 32'h0000_0140 :
            (a == 1 && m == 2) ? 32'h0001_0240 : 32'h0000_0008;
        `CHECK(unit_clock_enable, unit_set_t'({e[16], e[6], e[3]}))
        `CHECK(converter_sample_rate_sel, e[9:8])
        @(posedge mclk);
        axi_read(`DSG_OFS_EFF, d, r);
        `CHECK(d, e & `DSG_GATE_WMASK)
      end
    end
  endtask
  // Access to unclocked units, sticky status, mask and interrupt
  task automatic test_fault;
    power_mode <= mode_run;
    auto_clock_gating_enable <= 1'b0;
    run_clock_gate_0 <= 32'h0000_0000;
    axi_write(`DSG_OFS_MASK, 32'h0000_0001, r);
    axi_write(`DSG_OFS_STAT, 32'h0000_0007, r);
    repeat (2) @(posedge mclk);
    for (int i = 0; i < 3; i++) begin
      unit_access <= unit_set_t'(3'b001 << i);
      @(posedge mclk);
      unit_access <= 3'h0;
      @(negedge mclk);
      `CHECK(unit_access_fault, unit_set_t'(3'b001 << i))
      @(posedge mclk);
      @(negedge mclk);
      `CHECK(irq, 1'b1)
      @(posedge mclk);
    end
    axi_read(`DSG_OFS_STAT, d, r);
    `CHECK(d, 32'h0000_0007)
    axi_write(`DSG_OFS_STAT, 32'h0000_0001, r);
    axi_read(`DSG_OFS_STAT, d, r);
    `CHECK(d, 32'h0000_0006)
    `CHECK(irq, 1'b0)
    run_clock_gate_0 <= 32'h0001_0048;
    repeat (2) @(posedge mclk);
    unit_access <= 3'h7;
    @(posedge mclk);
    unit_access <= 3'h0;
    @(negedge mclk);
    `CHECK(unit_access_fault, 3'h0)
    `CHECK(unit_clock_enable, 3'h7)
    @(posedge mclk);
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    err_total = 0;
    tests_run = 0;
    reset = 1'b1;
    s_axi_awvalid = 1'b0;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    s_axi_awaddr = 12'h000;
    s_axi_araddr = 12'h000;
    s_axi_wdata = 32'h0000_0000;
    s_axi_wstrb = 4'h0;
    power_mode = mode_run;
    auto_clock_gating_enable = 1'b0;
    run_clock_gate_0 = 32'h0000_0000;
    sleep_clock_gate_0 = 32'h0000_0000;
    unit_access = 3'h0;
    repeat (3) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    test_reset();
    test_regs();
    test_select();
    test_fault();
    test_done();
  end
endmodule
`default_nettype wire
